// ---- inc/ds_defines.svh ----
/*
 * Object indices, subindices, control and status word bit positions
 * and reset values of the drive state block.
 * Assumes inclusion by bare name from a design file or a package.
 */
`ifndef DS_DEFINES_SVH
`define DS_DEFINES_SVH

`define DS_IDX_OPCOND        16'h4014
`define DS_IDX_ERRCODE       16'h603F
`define DS_IDX_CTRL          16'h6040
`define DS_IDX_STATUS        16'h6041

`define DS_SUB_COUNT         8'h00
`define DS_SUB_POWER_MV      8'h01
`define DS_SUB_LOGIC_MV      8'h02
`define DS_SUB_TEMP          8'h03
`define DS_OPCOND_COUNT_RST  8'h03

`define DS_CTRL_RST          16'h0000
`define DS_STATUS_RST        16'h0000
`define DS_ERRCODE_RST       16'h0000
`define DS_VALUE_RST         32'h0000_0000

`define DS_CW_SWITCH_ON      0
`define DS_CW_ENABLE_VOLT    1
`define DS_CW_QUICK_STOP     2
`define DS_CW_ENABLE_OP      3
`define DS_CW_FAULT_RESET    7
`define DS_CW_HOLD           8
`define DS_CW_MODE_LO        4
`define DS_CW_MODE_HI        6
`define DS_CW_MODE_EXTRA     9

`define DS_SW_READY          0
`define DS_SW_SWITCHED_ON    1
`define DS_SW_OP_ENABLED     2
`define DS_SW_FAULT          3
`define DS_SW_VOLTAGE        4
`define DS_SW_QUICK_STOP     5
`define DS_SW_SO_DISABLED    6
`define DS_SW_WARNING        7
`define DS_SW_BUS_LOCK       8
`define DS_SW_HOST_CTRL      9
`define DS_SW_SETPOINT       10
`define DS_SW_LIMIT          11
`define DS_SW_MODE_LO        12
`define DS_SW_MODE_HI        13
`define DS_SW_CLOSED_LOOP    15

`endif

// ---- inc/ds_pkg.sv ----
/*
 * Types of the drive state block: power state enumeration and the
 * packed register state of the top module.
 * Assumes ds_defines.svh is on the include path.
 */
package ds_pkg;

  typedef enum logic [2:0] {
    DS_NOT_READY,
    DS_SO_DISABLED,
    DS_READY,
    DS_SWITCHED_ON,
    DS_OP_ENABLED,
    DS_QUICK_STOP,
    DS_FAULT_REACTION,
    DS_FAULT
  } ds_power_t;

  typedef struct packed {
    ds_power_t    power;
    logic [15:0]  ctrl;
    logic [15:0]  status;
    logic [15:0]  err_code;
    logic [31:0]  power_mv;
    logic [31:0]  logic_mv;
    logic [31:0]  temp_dc;
    logic [31:0]  rdata;
    logic         ack;
    logic         err;
    logic         fr_prev;
    logic         index_seen;
    logic         halt;
    logic         volt_on;
    logic         op_on;
  } ds_state_t;

endpackage : ds_pkg

// ---- verilog/ds_drive_state.sv ----
/*
 * Drive state block: operating-condition array, last error code,
 * command word, report word and the power state machine they steer.
 * Assumes one-cycle object read/write strobes and same-clock inputs
 * from the drive core; no input needs synchronising.
 */
`timescale 1ns/1ps
`include "ds_defines.svh"

module ds_drive_state
  import ds_pkg::*;
(
  input  wire logic        mclk,             // 100 MHz clock
  input  wire logic        rst,              // Synchronous reset, high
  input  wire logic [15:0] obj_index,        // Object index
  input  wire logic [7:0]  obj_sub,          // Object subindex
  input  wire logic        obj_rd,           // Read strobe, one cycle
  input  wire logic        obj_wr,           // Write strobe, one cycle
  input  wire logic [31:0] obj_wdata,        // Write data
  output logic [31:0]      obj_rdata,        // Read data
  output logic             obj_ack,          // Answer pulse
  output logic             obj_err,          // Refused access
  input  wire logic [31:0] power_mv_in,      // Supply voltage sample
  input  wire logic [31:0] logic_mv_in,      // Logic voltage sample
  input  wire logic [31:0] temp_dc_in,       // Board temperature sample
  input  wire logic [31:0] err_history_in,   // Newest history entry
  input  wire logic        err_history_new,  // History entry update
  input  wire logic        fault_event,      // Error detected
  input  wire logic        fault_present,    // Error condition persists
  input  wire logic        reaction_done,    // Fault reaction finished
  input  wire logic        quick_stop_done,  // Quick stop ramp finished
  input  wire logic        voltage_present,  // Power stage has voltage
  input  wire logic        warning_in,       // Warning condition
  input  wire logic        bus_synced,       // Fieldbus in sync
  input  wire logic        setpoint_reached, // Target reached
  input  wire logic        limit_exceeded,   // Internal limit exceeded
  input  wire logic        auto_setup_ok,    // Auto setup succeeded
  input  wire logic        encoder_index,    // Encoder index pulse
  input  wire logic [1:0]  mode_status_in,   // Mode dependent status
  output logic [15:0]      state_command_word, // Command word
  output logic [15:0]      state_report_word,  // Report word
  output logic             halt_motion,      // Halt request to profiles
  output logic [3:0]       mode_specific_bits, // Command bits 9, 6..4
  output logic             voltage_enable,   // Power stage enable
  output logic             operation_enable, // Motion enable
  output logic             fault_indication  // Fault shown
);

  ds_state_t s;
  ds_state_t next_s;

  // Low byte pattern of the report word for each power state.
  function automatic logic [7:0] state_pattern(input ds_power_t p);
    logic [7:0] v;
    v = 8'h00;
    unique case (p)
      DS_NOT_READY:      v = 8'h00;
      DS_SO_DISABLED:    v = 8'h40;
      DS_READY:          v = 8'h21;
      DS_SWITCHED_ON:    v = 8'h23;
      DS_OP_ENABLED:     v = 8'h27;
      DS_QUICK_STOP:     v = 8'h07;
      DS_FAULT_REACTION: v = 8'h0F;
      DS_FAULT:          v = 8'h08;
    endcase
    return v;
  endfunction : state_pattern

  // Command decode helpers on the low three bits of the command word.
  function automatic logic cmd_shutdown(input logic [15:0] c);
    return c[`DS_CW_ENABLE_VOLT] && c[`DS_CW_QUICK_STOP] &&
           !c[`DS_CW_SWITCH_ON];
  endfunction : cmd_shutdown

  function automatic logic cmd_switch_on(input logic [15:0] c);
    return c[`DS_CW_ENABLE_VOLT] && c[`DS_CW_QUICK_STOP] &&
           c[`DS_CW_SWITCH_ON];
  endfunction : cmd_switch_on

  function automatic logic cmd_quick_stop(input logic [15:0] c);
    return c[`DS_CW_ENABLE_VOLT] && !c[`DS_CW_QUICK_STOP];
  endfunction : cmd_quick_stop

  logic fault_reset_edge;
  logic [15:0] sw;
  logic        rd_hit;
  logic [31:0] rd_val;
  logic        ro_obj;

  always_comb begin
    next_s = s;
    next_s.ack = 1'b0;
    next_s.err = 1'b0;
    fault_reset_edge = s.ctrl[`DS_CW_FAULT_RESET] && !s.fr_prev;
    next_s.fr_prev = s.ctrl[`DS_CW_FAULT_RESET];

    // Live values are captured every cycle so a read returns one
    // coherent registered sample.
    next_s.power_mv = power_mv_in;
    next_s.logic_mv = logic_mv_in;
    next_s.temp_dc = temp_dc_in;
    if (err_history_new) begin
      next_s.err_code = err_history_in[15:0];
    end

    // A pulse that arrives is latched until reset; setup loss alone
    // drops the flag through the AND below.
    if (encoder_index) begin
      next_s.index_seen = 1'b1;
    end

    // Power state machine.
    unique case (s.power)
      DS_NOT_READY: begin
        next_s.power = DS_SO_DISABLED;
      end
      DS_SO_DISABLED: begin
        if (cmd_shutdown(s.ctrl)) begin
          next_s.power = DS_READY;
        end
      end
      DS_READY: begin
        if (!s.ctrl[`DS_CW_ENABLE_VOLT] || cmd_quick_stop(s.ctrl)) begin
          next_s.power = DS_SO_DISABLED;
        end else if (cmd_switch_on(s.ctrl)) begin
          next_s.power = DS_SWITCHED_ON;
        end
      end
      DS_SWITCHED_ON: begin
        if (!s.ctrl[`DS_CW_ENABLE_VOLT] || cmd_quick_stop(s.ctrl)) begin
          next_s.power = DS_SO_DISABLED;
        end else if (cmd_shutdown(s.ctrl)) begin
          next_s.power = DS_READY;
        end else if (s.ctrl[`DS_CW_ENABLE_OP]) begin
          next_s.power = DS_OP_ENABLED;
        end
      end
      DS_OP_ENABLED: begin
        if (!s.ctrl[`DS_CW_ENABLE_VOLT]) begin
          next_s.power = DS_SO_DISABLED;
        end else if (cmd_quick_stop(s.ctrl)) begin
          next_s.power = DS_QUICK_STOP;
        end else if (cmd_shutdown(s.ctrl)) begin
          next_s.power = DS_READY;
        end else if (!s.ctrl[`DS_CW_ENABLE_OP]) begin
          next_s.power = DS_SWITCHED_ON;
        end
      end
      DS_QUICK_STOP: begin
        if (!s.ctrl[`DS_CW_ENABLE_VOLT] || quick_stop_done) begin
          next_s.power = DS_SO_DISABLED;
        end else if (cmd_switch_on(s.ctrl) && s.ctrl[`DS_CW_ENABLE_OP]) begin
          next_s.power = DS_OP_ENABLED;
        end
      end
      DS_FAULT_REACTION: begin
        if (reaction_done) begin
          next_s.power = DS_FAULT;
        end
      end
      DS_FAULT: begin
        // A held reset bit does not retry; a new rising edge is needed.
        if (fault_reset_edge && !fault_present) begin
          next_s.power = DS_SO_DISABLED;
        end
      end
    endcase

    // An error outranks every command except a fault reset taken in DS_FAULT.
    if (fault_event && s.power != DS_FAULT_REACTION &&
        s.power != DS_FAULT) begin
      next_s.power = DS_FAULT_REACTION;
    end

    // Object access; a write outranks a read in the same cycle.
    rd_hit = 1'b1;
    rd_val = `DS_VALUE_RST;
    ro_obj = 1'b1;
    if (obj_index == `DS_IDX_OPCOND) begin
      unique case (obj_sub)
        `DS_SUB_COUNT:    rd_val = {24'h00_0000, `DS_OPCOND_COUNT_RST};
        `DS_SUB_POWER_MV: rd_val = s.power_mv;
        `DS_SUB_LOGIC_MV: rd_val = s.logic_mv;
        `DS_SUB_TEMP:     rd_val = s.temp_dc;
        default:          rd_hit = 1'b0;
      endcase
    end else if (obj_sub != `DS_SUB_COUNT) begin
      rd_hit = 1'b0;
    end else if (obj_index == `DS_IDX_ERRCODE) begin
      rd_val = {16'h0000, s.err_code};
    end else if (obj_index == `DS_IDX_CTRL) begin
      rd_val = {16'h0000, s.ctrl};
      ro_obj = 1'b0;
    end else if (obj_index == `DS_IDX_STATUS) begin
      rd_val = {16'h0000, s.status};
    end else begin
      rd_hit = 1'b0;
    end

    if (obj_wr) begin
      next_s.ack = 1'b1;
      if (rd_hit && !ro_obj) begin
        next_s.ctrl = obj_wdata[15:0];
      end else begin
        next_s.err = 1'b1;
      end
    end else if (obj_rd) begin
      next_s.ack = 1'b1;
      next_s.err = !rd_hit;
      next_s.rdata = rd_hit ? rd_val : `DS_VALUE_RST;
    end

    // Report word built from the state now being entered.
    sw = `DS_STATUS_RST;
    sw[7:0] = state_pattern(next_s.power);
    sw[`DS_SW_VOLTAGE] = voltage_present;
    sw[`DS_SW_WARNING] = warning_in;
    sw[`DS_SW_BUS_LOCK] = bus_synced;
    sw[`DS_SW_HOST_CTRL] = 1'b1;
    sw[`DS_SW_SETPOINT] = setpoint_reached;
    sw[`DS_SW_LIMIT] = limit_exceeded;
    sw[`DS_SW_MODE_HI:`DS_SW_MODE_LO] = mode_status_in;
    sw[`DS_SW_CLOSED_LOOP] = auto_setup_ok &&
                             (next_s.index_seen);
    next_s.status = sw;

    next_s.halt = next_s.ctrl[`DS_CW_HOLD];
    next_s.volt_on = next_s.power == DS_SWITCHED_ON ||
                     next_s.power == DS_OP_ENABLED ||
                     next_s.power == DS_QUICK_STOP;
    next_s.op_on = next_s.power == DS_OP_ENABLED ||
                   next_s.power == DS_QUICK_STOP;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s.power <= DS_NOT_READY;
      s.ctrl <= `DS_CTRL_RST;
      s.status <= `DS_STATUS_RST;
      s.err_code <= `DS_ERRCODE_RST;
      s.power_mv <= `DS_VALUE_RST;
      s.logic_mv <= `DS_VALUE_RST;
      s.temp_dc <= `DS_VALUE_RST;
      s.rdata <= `DS_VALUE_RST;
      s.ack <= 1'b0;
      s.err <= 1'b0;
      s.fr_prev <= 1'b0;
      s.index_seen <= 1'b0;
      s.halt <= 1'b0;
      s.volt_on <= 1'b0;
      s.op_on <= 1'b0;
    end else begin
      s <= next_s;
    end
  end

  assign obj_rdata = s.rdata;
  assign obj_ack = s.ack;
  assign obj_err = s.err;
  assign state_command_word = s.ctrl;
  assign state_report_word = s.status;
  assign halt_motion = s.halt;
  // Mode bits are passed through untouched for the mode logic.
  assign mode_specific_bits = {s.ctrl[`DS_CW_MODE_EXTRA],
                               s.ctrl[`DS_CW_MODE_HI:`DS_CW_MODE_LO]};
  assign voltage_enable = s.volt_on;
  assign operation_enable = s.op_on;
  assign fault_indication = s.status[`DS_SW_FAULT];

endmodule : ds_drive_state

// ---- tb/ds_drive_state_properties.sv ----
/* Port assertions of the drive state block.
   Assumes a bind by name onto ds_drive_state and a single clock. */
`timescale 1ns/1ps

module ds_chk (
  input wire logic        mclk,               // Clock
  input wire logic        rst,                // Sync reset
  input wire logic [15:0] obj_index,          // Object index
  input wire logic [7:0]  obj_sub,            // Subindex
  input wire logic        obj_rd,             // Read strobe
  input wire logic        obj_wr,             // Write strobe
  input wire logic [31:0] obj_wdata,          // Write data
  input wire logic [31:0] obj_rdata,          // Read data
  input wire logic        obj_ack,            // Answer
  input wire logic        obj_err,            // Refusal
  input wire logic        fault_event,        // Error seen
  input wire logic        bus_synced,         // Bus sync
  input wire logic        setpoint_reached,   // Target
  input wire logic        limit_exceeded,     // Limit
  input wire logic        auto_setup_ok,      // Setup done
  input wire logic [15:0] state_command_word, // Command
  input wire logic [15:0] state_report_word,  // Report
  input wire logic        halt_motion,        // Halt
  input wire logic [3:0]  mode_specific_bits, // Mode bits
  input wire logic        fault_indication    // Fault shown
);
  wire [15:0] sw = state_report_word;
  wire [15:0] cw = state_command_word;
  wire [15:0] wd = obj_wdata[15:0];
  // Bit 4 is left out on purpose: it never takes part in decoding a state.
  wire [5:0]  lo = {sw[6], sw[5], sw[3:0]};

  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  chk_host_bit: assert property (!$past(rst) |-> sw[9])
    else $error("host bit low");
  chk_sync_bit: assert property (
    !$past(rst) |-> sw[8] == $past(bus_synced))
    else $error("sync bit wrong");
  chk_limit_target: assert property (!$past(rst) |->
    sw[11] == $past(limit_exceeded) && sw[10] == $past(setpoint_reached))
    else $error("limit or target bit wrong");
  chk_loop_ready: assert property (sw[15] |-> $past(auto_setup_ok))
    else $error("closed loop bit without setup");
  chk_state_code: assert property (lo inside {6'b0?_0000, 6'b1?_0000,
    6'b01_0001, 6'b01_0011, 6'b0?_0111, 6'b0?_1111, 6'b0?_1000})
    else $error("illegal state pattern");
  chk_fault_shape: assert property (sw[3] |-> !sw[6] &&
    (sw[2:0] == 3'b111 || sw[2:0] == 3'b000))
    else $error("bad fault pattern");
  chk_halt_mode: assert property (halt_motion == cw[8] &&
    mode_specific_bits == {cw[9], cw[6:4]})
    else $error("halt or mode bits wrong");
  chk_enable_op: assert property (
    lo == 6'b01_0011 && cw[3:0] == 4'hF && !fault_event |=>
    sw[2:0] == 3'b111)
    else $error("no operation enabled");
  chk_quick_stop: assert property (
    lo == 6'b01_0111 && cw[2:1] == 2'b01 && !fault_event |=>
    lo == 6'b00_0111)
    else $error("no quick stop");
  chk_cmd_write: assert property (
    obj_wr && obj_index == 16'h6040 && obj_sub == 8'h00 |=>
    obj_ack && !obj_err && cw == $past(wd))
    else $error("command word write lost");
  chk_fault_entry: assert property (
    fault_event && !sw[3] |=> sw[3] && fault_indication)
    else $error("fault not entered");
  chk_ro_write: assert property (obj_wr && obj_index == 16'h6041 |=>
    obj_ack && obj_err)
    else $error("report word write not refused");
  chk_count_read: assert property (obj_rd && !obj_wr &&
    obj_index == 16'h4014 && obj_sub == 8'h00 |=>
    obj_ack && !obj_err && obj_rdata == 32'h0000_0003)
    else $error("count read wrong");
endmodule : ds_chk

// ---- tb/ds_master.sv ----
/* Fieldbus master model issuing object reads and writes.
   Assumes the one-cycle strobe object port of ds_drive_state. */
`timescale 1ns/1ps

module ds_master (
  input  wire logic        mclk,      // Clock
  output logic [15:0]      obj_index, // Object index
  output logic [7:0]       obj_sub,   // Subindex
  output logic             obj_rd,    // Read strobe
  output logic             obj_wr,    // Write strobe
  output logic [31:0]      obj_wdata, // Write data
  input  wire logic [31:0] obj_rdata, // Read data
  input  wire logic        obj_ack,   // Answer
  input  wire logic        obj_err    // Refusal
);
  initial begin
    {obj_index, obj_sub, obj_rd, obj_wr, obj_wdata} = '0;
  end

  task automatic xfer(input logic w, input logic [15:0] i,
                      input logic [7:0] s, input logic [31:0] d,
                      output logic [31:0] q, output logic [1:0] ae);
    @(negedge mclk);
    obj_index = i;
    obj_sub   = s;
    obj_wdata = d;
    obj_wr    = w;
    obj_rd    = !w;
    @(posedge mclk);
    @(negedge mclk);
    q  = obj_rdata;
    ae = {obj_ack, obj_err};
    obj_wr = 1'b0;
    obj_rd = 1'b0;
    @(posedge mclk);
    // Released lines show a changed value so a stale match cannot pass.
    @(negedge mclk);
    obj_index = ~obj_index;
    obj_sub   = ~obj_sub;
    obj_wdata = ~obj_wdata;
  endtask : xfer
endmodule : ds_master

// ---- tb/ds_drive_state_tb.sv ----
/* Self-checking bench of the drive state block.
   Assumes ds_master drives the object port; core inputs come from here. */
`timescale 1ns/1ps

module ds_drive_state_tb;
  import ds_pkg::*;
  logic        mclk = 1'b0, rst = 1'b1;
  logic [15:0] obj_index, state_command_word, state_report_word;
  logic [7:0]  obj_sub;
  logic        obj_rd, obj_wr, obj_ack, obj_err, halt_motion;
  logic [31:0] obj_wdata, obj_rdata, q;
  logic [31:0] power_mv_in = '0, logic_mv_in = '0, temp_dc_in = '0;
  logic [31:0] err_history_in = '0;
  logic        err_history_new = 0, fault_event = 0, fault_present = 0;
  logic        reaction_done = 0, quick_stop_done = 0, voltage_present = 0;
  logic        warning_in = 0, bus_synced = 0, setpoint_reached = 0;
  logic        limit_exceeded = 0, auto_setup_ok = 0, encoder_index = 0;
  logic [1:0]  mode_status_in = '0, ae;
  logic [3:0]  mode_specific_bits;
  logic        voltage_enable, operation_enable, fault_indication;
  int          n_mismatch = 0, compares = 0;

  always #5 mclk = ~mclk;

  ds_drive_state dut_u (.*);
  ds_master      mst_u (.*);

  task automatic chk(input string nm, input logic [31:0] s, e);
    compares++;
    if (s !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task automatic st(input logic [15:0] m, e);
    chk("state", {16'h0000, state_report_word & m}, {16'h0000, e});
  endtask : st

  task automatic rd(input logic [15:0] i, input logic [7:0] s,
                    input logic [31:0] x, input logic e);
    mst_u.xfer(1'b0, i, s, 32'h0000_0000, q, ae);
    chk("read answer", {30'h0, ae}, {30'h0, 1'b1, e});
    chk("read data", q, x);
  endtask : rd

  task automatic wr(input logic [15:0] i, input logic [31:0] d,
                    input logic e);
    mst_u.xfer(1'b1, i, 8'h00, d, q, ae);
    chk("write answer", {30'h0, ae}, {30'h0, 1'b1, e});
  endtask : wr

  task automatic t_objects;
    @(negedge mclk);
    power_mv_in     = 32'h0000_5DC0;
    logic_mv_in     = 32'h0000_2EE0;
    temp_dc_in      = 32'hFFFF_FF9C;
    err_history_in  = 32'h1234_8130;
    err_history_new = 1;
    @(negedge mclk);
    err_history_new = 0;
    rd(16'h4014, 8'h00, 32'h0000_0003, 1'b0);
    rd(16'h4014, 8'h01, 32'h0000_5DC0, 1'b0);
    rd(16'h4014, 8'h02, 32'h0000_2EE0, 1'b0);
    rd(16'h4014, 8'h03, 32'hFFFF_FF9C, 1'b0);
    rd(16'h603F, 8'h00, 32'h0000_8130, 1'b0);
    wr(16'h4014, 32'h0000_0000, 1'b1);
    wr(16'h603F, 32'h0000_0000, 1'b1);
    wr(16'h6041, 32'h0000_FFFF, 1'b1);
    st(16'h004F, 16'h0040);
    chk("command kept", {16'h0000, state_command_word}, 32'h0);
    rd(16'h603F, 8'h00, 32'h0000_8130, 1'b0);
    rd(16'h4014, 8'h03, 32'hFFFF_FF9C, 1'b0);
    rd(16'h1234, 8'h00, 32'h0000_0000, 1'b1);
    $display("objects test done");
  endtask : t_objects

  task automatic t_power;
    st(16'h004F, 16'h0040);
    wr(16'h6040, 32'hFFFF_0006, 1'b0);
    st(16'h006F, 16'h0021);
    chk("command", {16'h0000, state_command_word}, 32'h0000_0006);
    wr(16'h6040, 32'h0000_0007, 1'b0);
    st(16'h006F, 16'h0023);
    chk("volt only", {30'h0, voltage_enable, operation_enable}, 32'h2);
    wr(16'h6040, 32'h0000_0006, 1'b0);
    st(16'h006F, 16'h0021);
    wr(16'h6040, 32'h0000_0007, 1'b0);
    wr(16'h6040, 32'h0000_000F, 1'b0);
    st(16'h006F, 16'h0027);
    chk("enables", {30'h0, voltage_enable, operation_enable}, 32'h3);
    rd(16'h6040, 8'h00, 32'h0000_000F, 1'b0);
    wr(16'h6040, 32'h0000_0007, 1'b0);
    st(16'h006F, 16'h0023);
    wr(16'h6040, 32'h0000_000F, 1'b0);
    wr(16'h6040, 32'h0000_000B, 1'b0);
    st(16'h006F, 16'h0007);
    wr(16'h6040, 32'h0000_000F, 1'b0);
    st(16'h006F, 16'h0027);
    wr(16'h6040, 32'h0000_000B, 1'b0);
    st(16'h006F, 16'h0007);
    quick_stop_done = 1;
    @(negedge mclk);
    quick_stop_done = 0;
    st(16'h004F, 16'h0040);
    chk("disabled", {30'h0, voltage_enable, operation_enable}, 32'h0);
    wr(16'h6040, 32'h0000_0006, 1'b0);
    st(16'h006F, 16'h0021);
    wr(16'h6040, 32'h0000_0000, 1'b0);
    st(16'h004F, 16'h0040);
    $display("power test done");
  endtask : t_power

  task automatic t_fault;
    fault_event   = 1;
    fault_present = 1;
    @(negedge mclk);
    fault_event = 0;
    st(16'h004F, 16'h000F);
    chk("fault out", {31'h0, fault_indication}, 32'h1);
    reaction_done = 1;
    @(negedge mclk);
    reaction_done = 0;
    st(16'h004F, 16'h0008);
    chk("fault en", {30'h0, voltage_enable, operation_enable}, 32'h0);
    wr(16'h6040, 32'h0000_0080, 1'b0);
    st(16'h004F, 16'h0008);
    wr(16'h6040, 32'h0000_0000, 1'b0);
    fault_present = 0;
    wr(16'h6040, 32'h0000_0080, 1'b0);
    st(16'h004F, 16'h0040);
    chk("fault gone", {31'h0, fault_indication}, 32'h0);
    $display("fault test done");
  endtask : t_fault

  task automatic t_flags;
    {bus_synced, limit_exceeded, setpoint_reached} = 3'b111;
    {auto_setup_ok, warning_in, voltage_present} = 3'b111;
    mode_status_in = 2'b10;
    @(negedge mclk);
    chk("no index", {31'h0, state_report_word[15]}, 32'h0);
    encoder_index = 1;
    @(negedge mclk);
    encoder_index = 0;
    @(negedge mclk);
    st(16'hBF90, 16'hAF90);
    bus_synced    = 0;
    auto_setup_ok = 0;
    wr(16'h6040, 32'h0000_0370, 1'b0);
    chk("sync off", {31'h0, state_report_word[8]}, 32'h0);
    chk("no setup", {31'h0, state_report_word[15]}, 32'h0);
    chk("halt", {31'h0, halt_motion}, 32'h1);
    chk("mode bits", {28'h0, mode_specific_bits}, 32'h0000_000F);
    chk("cmd mode", {16'h0000, state_command_word}, 32'h0000_0370);
    $display("flags test done");
  endtask : t_flags

  task end_sim;
    $display("comparisons %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_sim

  initial begin
    repeat (6) @(negedge mclk);
    chk("reset report", {16'h0000, state_report_word}, 32'h0);
    repeat (6) @(negedge mclk);
    rst = 1'b0;
    @(negedge mclk);
    t_objects();
    t_power();
    t_fault();
    t_flags();
    end_sim();
  end

  initial begin
    #100us;
    n_mismatch++;
    end_sim();
  end
endmodule : ds_drive_state_tb

bind ds_drive_state ds_chk chk_u (.*);
